// [rtl/nrs_host.sv]
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module nrs_host #(
  parameter int BUSY_TMO_CYC = nrs_pkg::BUSY_MAX_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_cle,
  output logic flash_ale,
  output logic flash_we_n,
  output logic flash_re_n,
  output logic flash_wp_n,
  output logic [7:0] flash_io_o,
  output logic flash_io_oe,
  input wire logic [7:0] flash_io_i,
  input wire logic flash_rb_n
);
  localparam int TW = $clog2(BUSY_TMO_CYC + 1);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CYC = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } nrs_st_e;

  nrs_cyc_if c ();
  nrs_st_e st_r;
  logic [2:0] op_r;
  logic [3:0] idx_r;
  logic go_r;
  logic [TW-1:0] tmo_cnt_r;
  logic rb_m_r, rb_s_r;
  logic unprot_r, tmo_r, bad_r, scan_r, retire_r, reloc_r;
  logic [7:0] stat_r, mfr_r, dev_r, m0_r, m5_r;
  logic [11:0] blk_r;
  logic [15:0] wmax_r, wmin_r, wthr_r;
  logic [9:0] step;
  logic last, start_req, tmo_hit, rb_ok;

  // ==========================================================
  // Bus cycle sequences of each operation
  function automatic logic [9:0] step_of(input logic [2:0] op,
      input logic [3:0] i, input logic [11:0] blk);
    logic [9:0] s;
    s = {nrs_pkg::K_RD, 8'h00};
    case (op)
      nrs_pkg::OP_RESET:
        s = (i == 4'h0) ? {nrs_pkg::K_CMD, nrs_pkg::C_RESET}
                        : {nrs_pkg::K_WAIT, 8'h00};
      nrs_pkg::OP_STATUS:
        if (i == 4'h0) s = {nrs_pkg::K_CMD, nrs_pkg::C_STATUS};
      nrs_pkg::OP_SIG:
        if (i == 4'h0) s = {nrs_pkg::K_CMD, nrs_pkg::C_SIG};
        else if (i == 4'h1) s = {nrs_pkg::K_ADR, nrs_pkg::SIG_ADDR};
      nrs_pkg::OP_BBM:
        case (i)
          4'h0: s = {nrs_pkg::K_CMD, nrs_pkg::C_SPARE};
          4'h1: s = {nrs_pkg::K_ADR, 8'h00};
          4'h2: s = {nrs_pkg::K_ADR, blk[2:0], 5'h00};
          4'h3: s = {nrs_pkg::K_ADR, blk[10:3]};
          4'h4: s = {nrs_pkg::K_ADR, 7'h00, blk[11]};
          nrs_pkg::BBM_WAIT_IDX: s = {nrs_pkg::K_WAIT, 8'h00};
          default: s = {nrs_pkg::K_RD, 8'h00};
        endcase
      default: s = {nrs_pkg::K_RD, 8'h00};
    endcase
    return s;
  endfunction : step_of

  function automatic logic [3:0] last_of(input logic [2:0] op);
    case (op)
      nrs_pkg::OP_SIG: return 4'h3;
      nrs_pkg::OP_BBM: return nrs_pkg::BBM_M5_IDX;
      default: return 4'h1;
    endcase
  endfunction : last_of

  assign step = step_of(op_r, idx_r, blk_r);
  assign last = (idx_r == last_of(op_r));
  assign start_req = reg_wr && reg_addr == nrs_pkg::A_CTRL &&
      reg_wdata[6:4] >= nrs_pkg::OP_RESET &&
      reg_wdata[6:4] <= nrs_pkg::OP_BBM;
  assign tmo_hit = tmo_cnt_r == TW'(BUSY_TMO_CYC - 1);
  assign rb_ok = rb_s_r && tmo_cnt_r >= TW'(nrs_pkg::WB_CYC);
  assign c.kind = step[9:8];
  assign c.wbyte = step[7:0];
  assign c.sel = go_r || st_r != nrs_pkg_idle();

  function automatic nrs_st_e nrs_pkg_idle();
    return ST_IDLE;
  endfunction : nrs_pkg_idle

  nrs_cycle u_cycle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .c(c),
    .ce_n(flash_ce_n),
    .cle(flash_cle),
    .ale(flash_ale),
    .we_n(flash_we_n),
    .re_n(flash_re_n),
    .io_o(flash_io_o),
    .io_oe(flash_io_oe),
    .io_i(flash_io_i)
  );

  // ==========================================================
  // Ready/busy synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_m_r <= 1'b0;
      rb_s_r <= 1'b0;
    end else begin
      rb_m_r <= flash_rb_n;
      rb_s_r <= rb_m_r;
    end
  end

  // ==========================================================
  // Operation sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      op_r <= 3'h0;
      idx_r <= 4'h0;
      go_r <= 1'b0;
      c.start <= 1'b0;
      tmo_cnt_r <= '0;
    end else begin
      c.start <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          if (start_req) begin
            op_r <= reg_wdata[6:4];
            idx_r <= 4'h0;
            st_r <= ST_CYC;
          end
        end
        ST_CYC: begin
          if (!go_r && c.kind == nrs_pkg::K_WAIT) begin
            tmo_cnt_r <= '0;
            st_r <= ST_WAIT;
          end else if (!go_r) begin
            c.start <= 1'b1;
            go_r <= 1'b1;
          end else if (c.done) begin
            go_r <= 1'b0;
            idx_r <= idx_r + 4'h1;
            if (last) st_r <= ST_DONE;
          end
        end
        ST_WAIT: begin
          tmo_cnt_r <= tmo_cnt_r + TW'(1);
          if (rb_ok) begin
            idx_r <= idx_r + 4'h1;
            st_r <= last ? ST_DONE : ST_CYC;
          end else if (tmo_hit) begin
            // A hung device gets a reset instead of a silent stall
            if (op_r != nrs_pkg::OP_RESET) begin
              op_r <= nrs_pkg::OP_RESET;
              idx_r <= 4'h0;
              st_r <= ST_CYC;
            end else begin
              st_r <= ST_DONE;
            end
          end
        end
        ST_DONE: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Captured answers and result flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= 8'h00;
      mfr_r <= 8'h00;
      dev_r <= 8'h00;
      m0_r <= 8'h00;
      m5_r <= 8'h00;
      tmo_r <= 1'b0;
      bad_r <= 1'b0;
      scan_r <= 1'b0;
      retire_r <= 1'b0;
    end else begin
      if (st_r == ST_IDLE && start_req) tmo_r <= 1'b0;
      if (st_r == ST_WAIT && !rb_ok && tmo_hit) tmo_r <= 1'b1;
      if (reg_wr && reg_addr == nrs_pkg::A_STATE &&
          reg_wdata[nrs_pkg::F_RETIRE]) retire_r <= 1'b0;
      if (st_r == ST_CYC && go_r && c.done && c.kind == nrs_pkg::K_RD) begin
        unique case (op_r)
          nrs_pkg::OP_STATUS: begin
            stat_r <= c.rbyte & nrs_pkg::STAT_MASK;
            if (c.rbyte[0]) retire_r <= 1'b1;
          end
          nrs_pkg::OP_SIG: begin
            if (idx_r == 4'h2) mfr_r <= c.rbyte;
            else dev_r <= c.rbyte;
          end
          nrs_pkg::OP_BBM: begin
            if (idx_r == nrs_pkg::BBM_M0_IDX) m0_r <= c.rbyte;
            if (idx_r == nrs_pkg::BBM_M5_IDX) m5_r <= c.rbyte;
          end
          default: ;
        endcase
      end
      if (st_r == ST_DONE && op_r == nrs_pkg::OP_BBM) begin
        bad_r <= m0_r != nrs_pkg::ERASED || m5_r != nrs_pkg::ERASED;
        scan_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unprot_r <= nrs_pkg::UNPROT_RST;
      flash_wp_n <= nrs_pkg::UNPROT_RST;
      blk_r <= 12'h000;
      wmax_r <= 16'h0000;
      wmin_r <= 16'h0000;
      wthr_r <= 16'h0000;
      reloc_r <= 1'b0;
    end else begin
      flash_wp_n <= unprot_r;
      reloc_r <= wmax_r >= wmin_r && wmax_r - wmin_r >= wthr_r;
      if (reg_wr) begin
        unique case (reg_addr)
          nrs_pkg::A_CTRL: unprot_r <= reg_wdata[nrs_pkg::F_UNPROT];
          nrs_pkg::A_BLOCK: blk_r <= reg_wdata[11:0];
          nrs_pkg::A_WEAR: begin
            wmax_r <= reg_wdata[15:0];
            wmin_r <= reg_wdata[31:16];
          end
          nrs_pkg::A_WTHR: wthr_r <= reg_wdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        nrs_pkg::A_CTRL: reg_rdata <= {25'h0, op_r, 3'h0, unprot_r};
        nrs_pkg::A_STATE: reg_rdata <= {15'h0, rb_s_r, stat_r, 2'h0,
            reloc_r, retire_r, scan_r, bad_r, tmo_r, st_r != ST_IDLE};
        nrs_pkg::A_SIG: reg_rdata <= {16'h0, dev_r, mfr_r};
        nrs_pkg::A_BLOCK: reg_rdata <= {20'h0, blk_r};
        nrs_pkg::A_WEAR: reg_rdata <= {wmin_r, wmax_r};
        nrs_pkg::A_WTHR: reg_rdata <= {16'h0, wthr_r};
        // Correction strength the data path must provide
        nrs_pkg::A_ECC: reg_rdata <= {12'h0, nrs_pkg::ECC_BITS,
            nrs_pkg::ECC_SECTOR_BYTES};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Reset request reaches the cycle engine two edges after the timeout
  tmo_reset_a: assert property (
      st_r == ST_WAIT && !rb_ok && tmo_hit &&
      op_r != nrs_pkg::OP_RESET |-> ##2 c.start && c.wbyte == 8'hFF)
    else $error("timeout did not issue reset");
  sig_addr_a: assert property (
      c.start && op_r == nrs_pkg::OP_SIG &&
      idx_r == 4'h1 |-> c.kind == nrs_pkg::K_ADR && c.wbyte == 8'h00)
    else $error("signature address not zero");
  status_mask_a: assert property (stat_r[5:1] == 5'h00)
    else $error("reserved status bits kept");
  status_cmd_a: assert property (
      c.start && op_r == nrs_pkg::OP_STATUS &&
      idx_r == 4'h0 |-> c.kind == nrs_pkg::K_CMD && c.wbyte == 8'h70)
    else $error("status op lacks its command");
  bad_mark_a: assert property (
      st_r == ST_DONE && op_r == nrs_pkg::OP_BBM
      |=> bad_r == (m0_r != 8'hFF || m5_r != 8'hFF) && scan_r)
    else $error("bad block verdict wrong");
  sig_cov: cover property (st_r == ST_DONE && op_r == nrs_pkg::OP_SIG);
  bbm_cov: cover property (st_r == ST_DONE && op_r == nrs_pkg::OP_BBM);
  tmo_cov: cover property (st_r == ST_WAIT && tmo_hit && !rb_ok);
endmodule : nrs_host
`default_nettype wire

// [rtl/nrs_pkg.sv]
package nrs_pkg;
  // ==========================================================
  // Timing
  localparam int PERIOD_NS = 20;
  localparam int T_STROBE_NS = 80;
  localparam int T_HOLD_NS = 40;
  localparam int T_WB_NS = 100;
  localparam int T_BUSY_MAX_NS = 3000000;
  localparam int STROBE_CYC = (T_STROBE_NS + PERIOD_NS - 1) / PERIOD_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + PERIOD_NS - 1) / PERIOD_NS;
  localparam int WB_CYC = (T_WB_NS + PERIOD_NS - 1) / PERIOD_NS;
  localparam int BUSY_MAX_CYC = T_BUSY_MAX_NS / PERIOD_NS;
  // ==========================================================
  // Flash command bytes and bus cycle kinds
  localparam logic [7:0] C_RESET = 8'hFF;
  localparam logic [7:0] C_STATUS = 8'h70;
  localparam logic [7:0] C_SIG = 8'h90;
  localparam logic [7:0] C_SPARE = 8'h50;
  localparam logic [7:0] SIG_ADDR = 8'h00;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] STAT_MASK = 8'hC1;
  localparam logic [1:0] K_CMD = 2'h0;
  localparam logic [1:0] K_ADR = 2'h1;
  localparam logic [1:0] K_RD = 2'h2;
  localparam logic [1:0] K_WAIT = 2'h3;
  // ==========================================================
  // Operations
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_STATUS = 3'h2;
  localparam logic [2:0] OP_SIG = 3'h3;
  localparam logic [2:0] OP_BBM = 3'h4;
  localparam logic [3:0] BBM_WAIT_IDX = 4'h5;
  localparam logic [3:0] BBM_M0_IDX = 4'h6;
  localparam logic [3:0] BBM_M5_IDX = 4'hB;
  // ==========================================================
  // Register map, byte addresses, and fields
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STATE = 5'h04;
  localparam logic [4:0] A_SIG = 5'h08;
  localparam logic [4:0] A_BLOCK = 5'h0C;
  localparam logic [4:0] A_WEAR = 5'h10;
  localparam logic [4:0] A_WTHR = 5'h14;
  localparam logic [4:0] A_ECC = 5'h18;
  localparam int F_UNPROT = 0;
  localparam int F_OP_LO = 4;
  localparam int F_RETIRE = 4;
  localparam logic [15:0] ECC_SECTOR_BYTES = 16'h0200;
  localparam logic [3:0] ECC_BITS = 4'h1;
  localparam logic UNPROT_RST = 1'b0;
endpackage : nrs_pkg

// [rtl/nrs_cyc_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface nrs_cyc_if;
  logic start;
  logic sel;
  logic [1:0] kind;
  logic [7:0] wbyte;
  logic done;
  logic [7:0] rbyte;
  modport ctl (output start, sel, kind, wbyte, input done, rbyte);
  modport eng (input start, sel, kind, wbyte, output done, rbyte);
endinterface : nrs_cyc_if
`default_nettype wire

// [rtl/nrs_cycle.sv]
`timescale 1ns/10ps
`default_nettype none
module nrs_cycle (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sequencer side
  nrs_cyc_if.eng c,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_o,
  output logic io_oe,
  input wire logic [7:0] io_i
);
  typedef enum logic [1:0] {
    EN_IDLE = 2'b00,
    EN_LOW = 2'b01,
    EN_HIGH = 2'b11
  } nrs_en_e;
  nrs_en_e st_r;
  logic [2:0] cnt_r;
  logic [7:0] io_m_r;
  logic [7:0] io_s_r;

  // ==========================================================
  // Pin input synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_m_r <= 8'h00;
      io_s_r <= 8'h00;
    end else begin
      io_m_r <= io_i;
      io_s_r <= io_m_r;
    end
  end

  // ==========================================================
  // Chip select follows the sequencer for the whole operation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_n <= 1'b1;
    end else begin
      ce_n <= ~c.sel;
    end
  end

  // ==========================================================
  // One bus cycle: strobe low, then hold high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= EN_IDLE;
      cnt_r <= 3'h0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_o <= 8'h00;
      io_oe <= 1'b0;
      c.done <= 1'b0;
      c.rbyte <= 8'h00;
    end else begin
      c.done <= 1'b0;
      unique case (st_r)
        EN_IDLE: begin
          if (c.start) begin
            cle <= (c.kind == nrs_pkg::K_CMD);
            ale <= (c.kind == nrs_pkg::K_ADR);
            io_oe <= (c.kind != nrs_pkg::K_RD);
            io_o <= c.wbyte;
            we_n <= (c.kind == nrs_pkg::K_RD);
            re_n <= (c.kind != nrs_pkg::K_RD);
            cnt_r <= 3'h0;
            st_r <= EN_LOW;
          end
        end
        EN_LOW: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'(nrs_pkg::STROBE_CYC - 1)) begin
            // Sampled late in the pulse so the two-flop delay settles
            if (!re_n) begin
              c.rbyte <= io_s_r;
            end
            we_n <= 1'b1;
            re_n <= 1'b1;
            cnt_r <= 3'h0;
            st_r <= EN_HIGH;
          end
        end
        EN_HIGH: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'(nrs_pkg::HOLD_CYC - 1)) begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            c.done <= 1'b1;
            st_r <= EN_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  we_width_a: assert property (
      $fell(we_n) |-> (!we_n)[*4] ##1 we_n)
    else $error("write strobe width wrong");
  write_drive_a: assert property (
      !we_n |-> io_oe && (cle ^ ale))
    else $error("write cycle without bus drive");
  read_float_a: assert property (
      !re_n |-> !io_oe && we_n && !cle && !ale)
    else $error("read cycle drives the bus");
endmodule : nrs_cycle
`default_nettype wire

// [test/nrs_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Behavioural flash device seen from the host pins
module nrs_flash_model #(
  parameter logic [7:0] MAN_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C, // Arbitrary value
  parameter int RST_IDLE = 8,
  parameter int RST_RUN = 30,
  parameter int RD_BUSY = 25
) (
  // Host pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_o,
  input wire logic io_oe,
  output logic [7:0] io_i,
  output logic rb_n,
  // Scenario controls
  input wire logic fail,
  input wire logic hang,
  input wire logic [1:0] bad_sel
);
  logic [7:0] mode = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] dout;
  logic [7:0] adr [0:3];
  logic rst_state = 1'b0;
  logic stuck = 1'b0;
  logic ptr_spare = 1'b0;
  int na = 0;
  int nrd = 0;
  int left = 0;
  int n_rst = 0;
  int n_abort = 0;
  // ==========================================================
  // Busy timing; the tick is off the host clock phase on purpose
  always #7 if (left > 0) left = left - 1;
  assign rb_n = (left == 0) && !stuck;
  // ==========================================================
  // Command and address latch on the write strobe rise
  always @(posedge we_n) if (!ce_n && io_oe) begin
    if (cle) begin
      na = 0;
      nrd = 0;
      if (io_o == 8'hFF) begin
        if (!rst_state) begin
          n_rst++;
          if (!rb_n) begin
            n_abort++;
            left = RST_RUN;
          end else begin
            left = RST_IDLE;
          end
          stuck = 1'b0;
          rst_state = 1'b1;
          ptr_spare = 1'b0;
          mode = 8'h00;
        end
      end else if (rb_n || io_o == 8'h70) begin
        rst_state = 1'b0;
        mode = io_o;
        if (io_o == 8'h50) ptr_spare = 1'b1;
      end
    end else if (ale && na < 4) begin
      adr[na] = io_o;
      na++;
      if (mode == 8'h50 && na == 4) begin
        left = RD_BUSY;
        stuck = hang;
      end
    end
  end
  // ==========================================================
  // Read data; a released bus shows the inverse of its last value
  always @(posedge re_n) if (!ce_n) begin
    last = dout;
    nrd++;
  end
  always @* begin
    case (mode)
      8'h70: dout = {wp_n, rb_n, 5'b10110, fail};
      8'h90: dout = (adr[0] != 8'h00) ? ~last : (nrd == 0) ? MAN_CODE :
        (nrd == 1) ? DEV_CODE : ~last;
      8'h50: dout = ((nrd == 0 && bad_sel[0]) || (nrd == 5 && bad_sel[1])) ?
        8'h00 : 8'hFF;
      default: dout = ~last;
    endcase
  end
  assign io_i = io_oe ? io_o :
    (!ce_n && !re_n) ? dout : ~last;
endmodule : nrs_flash_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
  logic [7:0] io_o, io_i;
  logic fail = 1'b0;
  logic hang = 1'b0;
  logic [1:0] bad_sel = 2'h0;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  logic [31:0] st;
  logic [31:0] d;
  always #10 core_clk = ~core_clk;
  // ==========================================================
  // Design and device
  nrs_host #(.BUSY_TMO_CYC(40)) i_nrs_host (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_ce_n(ce_n), .flash_cle(cle), .flash_ale(ale), .flash_we_n(we_n),
    .flash_re_n(re_n), .flash_wp_n(wp_n), .flash_io_o(io_o),
    .flash_io_oe(io_oe), .flash_io_i(io_i), .flash_rb_n(rb_n));
  nrs_flash_model i_nrs_flash_model (.ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_o(io_o), .io_oe(io_oe),
    .io_i(io_i), .rb_n(rb_n), .fail(fail), .hang(hang), .bad_sel(bad_sel));
  // ==========================================================
  // Register port cycles
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Bounded poll; a hung op shows up as a busy mismatch
  task automatic run_op(input logic [31:0] ctl, output logic [31:0] s);
    wr(nrs_pkg::A_CTRL, ctl);
    for (int i = 0; i < 300; i++) begin
      rd(nrs_pkg::A_STATE, s);
      if (s[0] === 1'b0) break;
    end
    `CHK("op_busy", 1'b0, s[0])
  endtask : run_op
  // ==========================================================
  // Scenarios
  task automatic t_reset_vals();
    rd(nrs_pkg::A_CTRL, d);
    `CHK("ctrl_rst", 32'h0, d & 32'h71)
    rd(nrs_pkg::A_STATE, d);
    // Zero gap meets the zero threshold, so relocate reads set
    `CHK("state_rst", 6'h20, d[5:0])
    rd(nrs_pkg::A_ECC, d);
    `CHK("ecc", 32'h00010200, d)
    rd(5'h1C, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("wp_rst", 1'b0, wp_n)
  endtask : t_reset_vals
  task automatic t_reset_op();
    n = i_nrs_flash_model.n_rst;
    run_op(32'h11, st);
    `CHK("reset_taken", n + 1, i_nrs_flash_model.n_rst)
    `CHK("wp_unprot", 1'b1, wp_n)
    run_op(32'h11, st);
    `CHK("reset_again", n + 1, i_nrs_flash_model.n_rst)
    `CHK("no_tmo", 1'b0, st[1])
  endtask : t_reset_op
  task automatic t_status();
    run_op(32'h20, st);
    `CHK("stat_prot", 8'h40, st[15:8])
    `CHK("rb_sync", 1'b1, st[16])
    fail <= 1'b1;
    run_op(32'h21, st);
    fail <= 1'b0;
    `CHK("stat_fail", 8'hC1, st[15:8])
    `CHK("retire", 1'b1, st[4])
    wr(nrs_pkg::A_STATE, 32'h10);
    rd(nrs_pkg::A_STATE, st);
    `CHK("retire_clr", 1'b0, st[4])
  endtask : t_status
  task automatic t_sig();
    run_op(32'h31, st);
    rd(nrs_pkg::A_SIG, d);
    `CHK("sig", 16'h3CA5, d[15:0])
    `CHK("sig_adr", 8'h00, i_nrs_flash_model.adr[0])
    rd(nrs_pkg::A_CTRL, d);
    `CHK("last_op", 32'h31, d & 32'h71)
  endtask : t_sig
  task automatic t_bbm();
    wr(nrs_pkg::A_BLOCK, 32'h9AB);
    for (int b = 0; b < 4; b++) begin
      bad_sel <= b[1:0];
      run_op(32'h41, st);
      `CHK("bad", b != 0, st[2])
      `CHK("scanned", 1'b1, st[3])
    end
    bad_sel <= 2'h0;
    d = {8'h00, i_nrs_flash_model.adr[3], i_nrs_flash_model.adr[2],
      i_nrs_flash_model.adr[1]};
    `CHK("blk_adr", 32'h00013560, d)
  endtask : t_bbm
  task automatic t_timeout();
    hang <= 1'b1;
    n = i_nrs_flash_model.n_abort;
    run_op(32'h41, st);
    hang <= 1'b0;
    `CHK("tmo", 1'b1, st[1])
    `CHK("abort", n + 1, i_nrs_flash_model.n_abort)
    run_op(32'h21, st);
    `CHK("tmo_clr", 1'b0, st[1])
    `CHK("stat_after", 8'hC0, st[15:8])
  endtask : t_timeout
  task automatic t_wear();
    wr(nrs_pkg::A_WEAR, 32'h0003000A);
    wr(nrs_pkg::A_WTHR, 32'h7);
    rd(nrs_pkg::A_STATE, st);
    `CHK("reloc_at", 1'b1, st[5])
    wr(nrs_pkg::A_WTHR, 32'h8);
    rd(nrs_pkg::A_STATE, st);
    `CHK("reloc_below", 1'b0, st[5])
  endtask : t_wear
  task automatic t_refuse();
    wr(nrs_pkg::A_CTRL, 32'h51);
    rd(nrs_pkg::A_STATE, st);
    `CHK("bad_op", 1'b0, st[0])
    `CHK("deselect", 1'b1, ce_n)
  endtask : t_refuse
  // ==========================================================
  // Verdict and run control
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_reset_op();
    t_status();
    t_sig();
    t_bbm();
    t_timeout();
    t_wear();
    t_refuse();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
